// ===== sgc_top.sv
// What this block does
// - Open-contact only: high OFF, low ON
// - Three interlocks per direction block that direction
// - Protection open and reclose bypass interlocks
// - Trip sources ORed into one trip
// - Only trip manager output drives breaker
// - Trip held for minimum hold time
// - Latching holds trip until acknowledged
// - Latch clears after sources drop, on ack
// - No assigned sources clears the latch
// - One external close and one open source
// - Open wins over simultaneous close
// - Close on rising edge, open on level
// - SCADA only with remote or both authority
// - Close needs sync release within wait time
// - Sync wait starts at close issue
// - No sync source means permanent release
// - Authority never affects protection trips
// - Authority none rejects operational commands
// - Authority local accepts panel only
// - Authority remote: SCADA and external inputs
// - Local and remote accepts all sources
// - Interlock checks can be disabled
// - Position codes 0,1,2,3 meaning fixed
`timescale 1ns/1ns
`include "sgc_params.svh"

module sgc_top #(
  parameter int NUM_TRIP = `SGC_NUM_TRIP,
  parameter int NUM_IL   = `SGC_NUM_IL,
  parameter int HOLD_CYC = `SGC_MIN_HOLD_CYC,
  parameter int SYNC_CYC = `SGC_SYNC_WAIT_CYC
) (
  // Clock and reset
  input  wire logic                MCLK_I,
  input  wire logic                RESETN_I,
  // Position contact
  input  wire logic                AUX_OPEN_I,
  input  wire logic                AUX_OPEN_ASSIGNED_I,
  // Interlocks
  input  wire logic [NUM_IL-1:0]   IL_CLOSE_I,
  input  wire logic [NUM_IL-1:0]   IL_OPEN_I,
  input  wire logic                IL_DISABLE_I,
  // Protection
  input  wire logic [NUM_TRIP-1:0] TRIP_SRC_I,
  input  wire logic [NUM_TRIP-1:0] TRIP_ASSIGN_I,
  input  wire logic                LATCH_EN_I,
  input  wire logic                TRIP_ACK_I,
  input  wire logic                TRIP_CLEAR_SOURCE_I,
  input  wire logic                PROT_OPEN_BLOCK_I,
  input  wire logic                AUTO_RECLOSE_I,
  // Operational requests
  input  wire logic                PANEL_CLOSE_I,
  input  wire logic                PANEL_OPEN_I,
  input  wire logic                SCADA_CLOSE_I,
  input  wire logic                SCADA_OPEN_I,
  input  wire logic                EXT_CLOSE_SOURCE_I,
  input  wire logic                EXT_OPEN_SOURCE_I,
  input  wire logic [1:0]          AUTHORITY_I,
  // Synchronism
  input  wire logic                SYNC_ASSIGNED_I,
  input  wire logic                SYNCCHECK_RELEASE_I,
  // Switchgear commands and status
  output logic                     BREAKER_TRIP_O,
  output logic                     BREAKER_CLOSE_O,
  output logic                     BREAKER_OPEN_O,
  output logic                     SYNC_FAIL_O,
  output logic [1:0]               POS_O
);

  initial begin
    if (NUM_IL < 1 || NUM_IL > 3 || SYNC_CYC < 1) begin
      $error("sgc_top: bad parameters");
    end
  end

  localparam int SW = $clog2(SYNC_CYC + 1);

  // ---------------------------------------------------------------
  // Position decode
  // ---------------------------------------------------------------
  wire [1:0] next_pos = !AUX_OPEN_ASSIGNED_I ? `SGC_POS_DISTURB :
                        AUX_OPEN_I ? `SGC_POS_OFF : `SGC_POS_ON;

  // ---------------------------------------------------------------
  // Authority gating
  // ---------------------------------------------------------------
  function automatic logic allow_local(input logic [1:0] a);
    allow_local = (a == `SGC_AUTH_LOCAL) || (a == `SGC_AUTH_BOTH);
  endfunction

  function automatic logic allow_remote(input logic [1:0] a);
    allow_remote = (a == `SGC_AUTH_REMOTE) || (a == `SGC_AUTH_BOTH);
  endfunction

  sgc_pkg::sgc_req_s close_req;
  sgc_pkg::sgc_req_s open_req;
  assign close_req = '{PANEL_CLOSE_I, SCADA_CLOSE_I, EXT_CLOSE_SOURCE_I};
  assign open_req  = '{PANEL_OPEN_I, SCADA_OPEN_I, EXT_OPEN_SOURCE_I};

  wire loc = allow_local(AUTHORITY_I);
  wire rem = allow_remote(AUTHORITY_I);

  wire close_lvl = (loc & close_req.panel) |
                   (rem & (close_req.scada | close_req.ext));
  wire open_lvl  = (loc & open_req.panel) |
                   (rem & (open_req.scada | open_req.ext));

  // ---------------------------------------------------------------
  // Interlocks and priority
  // ---------------------------------------------------------------
  wire il_close = ~IL_DISABLE_I & (|IL_CLOSE_I);
  wire il_open  = ~IL_DISABLE_I & (|IL_OPEN_I);

  logic close_lvl_d;
  wire  close_edge = close_lvl & ~close_lvl_d;
  wire  op_open    = open_lvl & ~il_open;
  wire  op_close   = close_edge & ~il_close & ~open_lvl;

  // ---------------------------------------------------------------
  // Synchronism supervision
  // ---------------------------------------------------------------
  sgc_pkg::sgc_sync_e state;
  sgc_pkg::sgc_sync_e next_state;
  logic [SW-1:0]      sync_cnt;
  logic [SW-1:0]      next_sync_cnt;
  wire  sync_ok  = ~SYNC_ASSIGNED_I | SYNCCHECK_RELEASE_I;
  wire  timeout  = sync_cnt == '0;
  logic next_close;
  logic next_fail;

  always_comb begin
    next_state    = state;
    next_sync_cnt = sync_cnt;
    next_close    = 1'b0;
    next_fail     = 1'b0;
    unique case (state)
      sgc_pkg::SGC_IDLE: begin
        if (op_close) begin
          next_state    = sgc_pkg::SGC_WAIT;
          next_sync_cnt = SW'(SYNC_CYC - 1);
        end
      end
      sgc_pkg::SGC_WAIT: begin
        if (op_open) begin
          next_state = sgc_pkg::SGC_IDLE;
        end else if (sync_ok) begin
          next_close = 1'b1;
          next_state = sgc_pkg::SGC_DONE;
        end else if (timeout) begin
          next_fail  = 1'b1;
          next_state = sgc_pkg::SGC_DONE;
        end else begin
          next_sync_cnt = sync_cnt - 1'b1;
        end
      end
      sgc_pkg::SGC_DONE: begin
        next_state = sgc_pkg::SGC_IDLE;
      end
      default: begin
        next_state = sgc_pkg::SGC_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Trip manager
  // ---------------------------------------------------------------
  logic trip;
  wire  ack = TRIP_ACK_I | TRIP_CLEAR_SOURCE_I;

  sgc_trip_mgr #(
    .NUM_TRIP (NUM_TRIP),
    .HOLD_CYC (HOLD_CYC)
  ) u_trip (
    .clk         (MCLK_I),
    .rst_n       (RESETN_I),
    .trip_src    (TRIP_SRC_I),
    .trip_assign (TRIP_ASSIGN_I),
    .latch_en    (LATCH_EN_I),
    .ack         (ack),
    .trip        (trip)
  );

  // Protection path ignores interlocks and authority
  wire next_trip_o  = trip & ~PROT_OPEN_BLOCK_I;
  wire next_close_o = (next_close | AUTO_RECLOSE_I) &
                      ~next_trip_o;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state           <= sgc_pkg::SGC_IDLE;
      sync_cnt        <= '0;
      close_lvl_d     <= 1'b0;
      BREAKER_TRIP_O  <= 1'b0;
      BREAKER_CLOSE_O <= 1'b0;
      BREAKER_OPEN_O  <= 1'b0;
      SYNC_FAIL_O     <= 1'b0;
      POS_O           <= `SGC_POS_INDETERM;
    end else begin
      state           <= next_state;
      sync_cnt        <= next_sync_cnt;
      close_lvl_d     <= close_lvl;
      BREAKER_TRIP_O  <= next_trip_o;
      BREAKER_CLOSE_O <= next_close_o;
      BREAKER_OPEN_O  <= op_open;
      SYNC_FAIL_O     <= next_fail;
      POS_O           <= next_pos;
    end
  end

endmodule

// ===== sgc_params.svh
// Constants for the switchgear command control block
`ifndef SGC_PARAMS_SVH
`define SGC_PARAMS_SVH

`define SGC_CLK_MHZ          125
`define SGC_POS_INDETERM     2'h0
`define SGC_POS_OFF          2'h1
`define SGC_POS_ON           2'h2
`define SGC_POS_DISTURB      2'h3
`define SGC_AUTH_NONE        2'h0
`define SGC_AUTH_LOCAL       2'h1
`define SGC_AUTH_REMOTE      2'h2
`define SGC_AUTH_BOTH        2'h3
`define SGC_NUM_IL           3
`define SGC_NUM_TRIP         8
`define SGC_MIN_HOLD_US      1
`define SGC_SYNC_WAIT_US     100
`define SGC_MIN_HOLD_CYC     (`SGC_MIN_HOLD_US * `SGC_CLK_MHZ)
`define SGC_SYNC_WAIT_CYC    (`SGC_SYNC_WAIT_US * `SGC_CLK_MHZ)

`endif

// ===== sgc_pkg.sv
// Types for the switchgear command control block
package sgc_pkg;

  typedef enum logic [1:0] {
    SGC_IDLE = 2'h0,
    SGC_WAIT = 2'h1,
    SGC_DONE = 2'h3
  } sgc_sync_e;

  // Command requests by origin
  typedef struct packed {
    logic panel;
    logic scada;
    logic ext;
  } sgc_req_s;

endpackage

// ===== sgc_trip_mgr.sv
// Trip manager: OR of trip sources, hold time and latching
`timescale 1ns/1ns
`include "sgc_params.svh"

module sgc_trip_mgr #(
  parameter int NUM_TRIP = `SGC_NUM_TRIP,
  parameter int HOLD_CYC = `SGC_MIN_HOLD_CYC
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic [NUM_TRIP-1:0] trip_src,
  input  wire logic [NUM_TRIP-1:0] trip_assign,
  input  wire logic                latch_en,
  input  wire logic                ack,
  output logic                     trip
);

  initial begin
    if (NUM_TRIP < 1 || HOLD_CYC < 1) begin
      $error("sgc_trip_mgr: bad parameters");
    end
  end

  localparam int CW = $clog2(HOLD_CYC + 1);

  logic [CW-1:0] hold_cnt;
  logic          latched;
  wire           any_trip  = |(trip_src & trip_assign);
  wire           none_asgn = ~|trip_assign;
  wire           hold_run  = hold_cnt != '0;
  wire           clr_latch = ~any_trip & (ack | ~latch_en | none_asgn);
  wire           rise      = any_trip & ~trip;
  wire [CW-1:0]  next_hold = rise ? CW'(HOLD_CYC - 1) :
                             (hold_run ? hold_cnt - 1'b1 : hold_cnt);
  wire           next_latched = (any_trip & latch_en) |
                                (latched & ~clr_latch);
  wire           next_trip = any_trip | hold_run | next_latched;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_cnt <= '0;
      latched  <= 1'b0;
      trip     <= 1'b0;
    end else begin
      hold_cnt <= next_hold;
      latched  <= next_latched;
      trip     <= next_trip;
    end
  end

endmodule

// ===== sgc_top_properties.sv
// Port checker for the switchgear command control block
`timescale 1ns/1ns
`include "sgc_params.svh"
module sgc_top_checker #(
  parameter int HOLD_CYC = 4
) (
  input wire logic       MCLK_I,
  input wire logic       RESETN_I,
  input wire logic       AUX_OPEN_I,
  input wire logic       AUX_OPEN_ASSIGNED_I,
  input wire logic [2:0] IL_OPEN_I,
  input wire logic       IL_DISABLE_I,
  input wire logic [7:0] TRIP_SRC_I,
  input wire logic [7:0] TRIP_ASSIGN_I,
  input wire logic       PROT_OPEN_BLOCK_I,
  input wire logic       SYNC_ASSIGNED_I,
  input wire logic       BREAKER_TRIP_O,
  input wire logic       BREAKER_OPEN_O,
  input wire logic       SYNC_FAIL_O,
  input wire logic [1:0] POS_O
);
  int hcnt;
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RESETN_I);
  // ----------------------------------------
  // Trip high time and assertions
  // ----------------------------------------
  always_ff @(posedge MCLK_I or negedge RESETN_I)
    if (!RESETN_I) hcnt <= 0;
    else hcnt <= BREAKER_TRIP_O ? hcnt + 1 : 0;
  property p_pos; AUX_OPEN_ASSIGNED_I |=>
    POS_O == ($past(AUX_OPEN_I) ? `SGC_POS_OFF : `SGC_POS_ON); endproperty
  a_pos: assert property (p_pos) else $error("position code");
  property p_pos_dist;
    !AUX_OPEN_ASSIGNED_I |=> POS_O == `SGC_POS_DISTURB; endproperty
  a_pos_dist: assert property (p_pos_dist) else $error("disturbed");
  property p_trip_or; |(TRIP_SRC_I & TRIP_ASSIGN_I) ##1 !PROT_OPEN_BLOCK_I
    |=> BREAKER_TRIP_O; endproperty
  a_trip_or: assert property (p_trip_or) else $error("trip or");
  property p_trip_cause; $rose(BREAKER_TRIP_O)
    |-> $past(|(TRIP_SRC_I & TRIP_ASSIGN_I), 2) ||
        $past(PROT_OPEN_BLOCK_I, 2); endproperty
  a_trip_cause: assert property (p_trip_cause) else $error("cause");
  property p_hold; $fell(BREAKER_TRIP_O) && !$past(PROT_OPEN_BLOCK_I)
    |-> hcnt >= HOLD_CYC; endproperty
  a_hold: assert property (p_hold) else $error("hold time");
  property p_unassigned;
    (TRIP_ASSIGN_I == 8'h0) [*6] |=> !BREAKER_TRIP_O; endproperty
  a_unassigned: assert property (p_unassigned) else $error("no slot");
  property p_open_il;
    IL_OPEN_I != 3'h0 && !IL_DISABLE_I |=> !BREAKER_OPEN_O; endproperty
  a_open_il: assert property (p_open_il) else $error("interlock");
  property p_sync; SYNC_FAIL_O |-> $past(SYNC_ASSIGNED_I); endproperty
  a_sync: assert property (p_sync) else $error("sync fail");
endmodule
bind sgc_top sgc_top_checker #(.HOLD_CYC(HOLD_CYC)) i_chk (.*);

// ===== sgc_breaker_model.sv
// Breaker model that answers commands on its open contact
`timescale 1ns/1ns
module sgc_breaker #(
  parameter int DLY = 2
) (
  input  wire logic clk_i,
  input  wire logic close_i,
  input  wire logic open_i,
  output logic      aux_open_o
);
  logic want = 1'b1;
  int   cnt  = 0;
  initial aux_open_o = 1'b1;
  // Open wins, contact follows DLY+1 cycles after want changes
  always @(posedge clk_i) begin
    if (close_i && !open_i) want <= 1'b0;
    if (open_i) want <= 1'b1;
    cnt <= aux_open_o == want ? 0 : cnt + 1;
    if (cnt >= DLY) aux_open_o <= want;
  end
endmodule

// ===== test_sgc_top.sv
// Self-checking bench for the switchgear command control block
`timescale 1ns/1ns
`include "sgc_params.svh"
module test_sgc_top;
  logic MCLK_I, RESETN_I, AUX_OPEN_ASSIGNED_I, IL_DISABLE_I, LATCH_EN_I;
  logic TRIP_ACK_I, TRIP_CLEAR_SOURCE_I, PROT_OPEN_BLOCK_I, AUTO_RECLOSE_I;
  logic PANEL_CLOSE_I, PANEL_OPEN_I, SCADA_CLOSE_I, SCADA_OPEN_I, mlat;
  logic EXT_CLOSE_SOURCE_I, EXT_OPEN_SOURCE_I, SYNC_ASSIGNED_I, SYNC_FAIL_O;
  logic SYNCCHECK_RELEASE_I, BREAKER_TRIP_O, BREAKER_CLOSE_O, BREAKER_OPEN_O;
  logic [2:0]  IL_CLOSE_I, IL_OPEN_I;
  logic [7:0]  TRIP_SRC_I, TRIP_ASSIGN_I;
  logic [1:0]  AUTHORITY_I, POS_O;
  logic [31:0] rs = 32'h0000aee6;
  wire         AUX_OPEN_I;
  int          error_cnt = 0, comparisons = 0, cyc = 0;
  sgc_top #(.HOLD_CYC(4), .SYNC_CYC(10)) i_dut (.*);
  sgc_breaker i_brk (.clk_i(MCLK_I), .close_i(BREAKER_CLOSE_O),
    .open_i(BREAKER_OPEN_O | BREAKER_TRIP_O), .aux_open_o(AUX_OPEN_I));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  task automatic chk(input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic step();
    logic [31:0] r;
    logic        s;
    logic        e;
    r = rnd();
    @(posedge MCLK_I);
    {PANEL_OPEN_I, SCADA_OPEN_I, EXT_OPEN_SOURCE_I, AUTHORITY_I} <= r[4:0];
    {IL_OPEN_I, IL_DISABLE_I, LATCH_EN_I, TRIP_ACK_I} <= r[10:5];
    {TRIP_CLEAR_SOURCE_I, AUX_OPEN_ASSIGNED_I} <= r[12:11];
    TRIP_SRC_I <= r[20:13] & {8{r[29]}};
    TRIP_ASSIGN_I <= r[28:21] & {8{r[30] | r[31]}};
    repeat (12) @(posedge MCLK_I);
    #1;
    s = |(TRIP_SRC_I & TRIP_ASSIGN_I);
    mlat = s & LATCH_EN_I | mlat & (s | !(TRIP_ACK_I | TRIP_CLEAR_SOURCE_I
           | !LATCH_EN_I | TRIP_ASSIGN_I == 8'h0));
    chk(BREAKER_TRIP_O, s | mlat);
    e = (PANEL_OPEN_I & AUTHORITY_I[0] | (SCADA_OPEN_I | EXT_OPEN_SOURCE_I)
        & AUTHORITY_I[1]) & (IL_OPEN_I == 3'h0 | IL_DISABLE_I);
    chk(BREAKER_OPEN_O, e);
    chk(POS_O, AUX_OPEN_ASSIGNED_I ? (AUX_OPEN_I ? `SGC_POS_OFF : `SGC_POS_ON)
        : `SGC_POS_DISTURB);
  endtask
  task automatic pulse(input logic [2:0] req, input int rel, ecl, efl);
    int ncl;
    int nfl;
    ncl = 0;
    nfl = 0;
    @(posedge MCLK_I);
    {PANEL_CLOSE_I, SCADA_CLOSE_I, EXT_CLOSE_SOURCE_I} <= req;
    for (int i = 0; i < 16; i++) begin
      @(posedge MCLK_I);
      if (i == rel) SYNCCHECK_RELEASE_I <= 1'b1;
      #1;
      ncl += BREAKER_CLOSE_O === 1'b1;
      nfl += SYNC_FAIL_O === 1'b1;
    end
    @(posedge MCLK_I);
    {PANEL_CLOSE_I, SCADA_CLOSE_I, EXT_CLOSE_SOURCE_I} <= 3'h0;
    {EXT_OPEN_SOURCE_I, SYNCCHECK_RELEASE_I} <= 2'h0;
    repeat (3) @(posedge MCLK_I);
    chk(ncl, ecl);
    chk(nfl, efl);
  endtask
  // ----------------------------------------
  // Clock, timeout and main sequence
  // ----------------------------------------
  initial begin
    MCLK_I = 1'b0;
    forever #4 MCLK_I = ~MCLK_I;
  end
  always @(posedge MCLK_I) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin
    {RESETN_I, AUX_OPEN_ASSIGNED_I, IL_DISABLE_I, LATCH_EN_I, TRIP_ACK_I} = '0;
    {TRIP_CLEAR_SOURCE_I, PROT_OPEN_BLOCK_I, AUTO_RECLOSE_I, mlat} = '0;
    {PANEL_CLOSE_I, PANEL_OPEN_I, SCADA_CLOSE_I, SCADA_OPEN_I} = '0;
    {EXT_CLOSE_SOURCE_I, EXT_OPEN_SOURCE_I, SYNC_ASSIGNED_I} = '0;
    {SYNCCHECK_RELEASE_I, IL_CLOSE_I, IL_OPEN_I, TRIP_SRC_I} = '0;
    {TRIP_ASSIGN_I, AUTHORITY_I} = '0;
    repeat (6) @(posedge MCLK_I);
    RESETN_I <= 1'b1;
    repeat (40) step();
    {TRIP_SRC_I, TRIP_ASSIGN_I, IL_OPEN_I, IL_DISABLE_I} <= '0;
    {PANEL_OPEN_I, SCADA_OPEN_I, EXT_OPEN_SOURCE_I} <= '0;
    repeat (8) @(posedge MCLK_I);
    #1;
    chk(BREAKER_TRIP_O, 1'b0);
    for (int k = 0; k < 16; k++) begin
      @(posedge MCLK_I);
      AUTHORITY_I <= k[1:0];
      IL_CLOSE_I <= k > 11 ? {k[0], ~k[0], k[1]} : 3'h0;
      pulse(k < 4 ? 3'h4 : (k < 8 ? 3'h2 : 3'h1), 99,
            k < 4 ? k % 2 : (k < 12 ? k / 2 % 2 : 0), 0);
    end
    @(posedge MCLK_I);
    {AUTHORITY_I, IL_CLOSE_I, IL_DISABLE_I} <= {2'h2, 3'h7, 1'b1};
    pulse(3'h1, 99, 1, 0);
    @(posedge MCLK_I);
    {IL_CLOSE_I, IL_DISABLE_I, EXT_OPEN_SOURCE_I} <= 5'h01;
    pulse(3'h1, 99, 0, 0);
    @(posedge MCLK_I);
    SYNC_ASSIGNED_I <= 1'b1;
    pulse(3'h1, 99, 0, 1);
    pulse(3'h1, 3, 1, 0);
    @(posedge MCLK_I);
    {AUTHORITY_I, IL_CLOSE_I, AUTO_RECLOSE_I} <= {2'h0, 3'h7, 1'b1};
    @(posedge MCLK_I);
    AUTO_RECLOSE_I <= 1'b0;
    #1;
    chk(BREAKER_CLOSE_O, 1'b1);
    @(posedge MCLK_I);
    {TRIP_SRC_I, TRIP_ASSIGN_I, PROT_OPEN_BLOCK_I} <= {8'h01, 8'h01, 1'b1};
    repeat (4) @(posedge MCLK_I);
    #1;
    chk(BREAKER_TRIP_O, 1'b0);
    @(posedge MCLK_I);
    PROT_OPEN_BLOCK_I <= 1'b0;
    repeat (3) @(posedge MCLK_I);
    #1;
    chk(BREAKER_TRIP_O, 1'b1);
    give_verdict();
  end
endmodule
